// file: hdl/sef_status_enh_fsm.v
// read status enhanced command state machine of the target
// How it works
// - each wait state cycle clears the status enhanced pending flag unless a set arrives in it.
// - wait state sets status output flag so reads return status.
// - stay waiting until a row address cycle arrives, then store.
// - wait state latches the received cycle into its row address byte.
// - more cycles needed returns to the wait state.
// - all cycles stored advances to lun selection.
// - selection loads selected lun from the received row address.
// - selection pulses 78h notice with row address to every lun.
// - leave to idle read if return state idle, else saved state.
// - plain 70h while pending is illegal and not honoured.
// - read request with status output set goes to status read idle.
`timescale 1ns/100ps
`default_nettype none
`include "sef_defs.vh"
module sef_status_enh_fsm (
  input wire i_ref_clk, // 20 mhz clock
  input wire i_sys_rst, // sync reset, high
  input wire i_psel, // apb select
  input wire i_penable, // apb enable
  input wire i_pwrite, // apb direction
  input wire [7:0] i_paddr, // apb byte address
  input wire [31:0] i_pwdata, // apb write data
  output wire [31:0] o_prdata, // apb read data
  output wire o_pready, // apb ready
  output wire o_pslverr, // apb error
  input wire i_cmd_valid, // command cycle strobe
  input wire [7:0] i_cmd, // command code
  input wire i_addr_valid, // address cycle strobe
  input wire [7:0] i_addr, // address cycle value
  input wire i_read_req, // host data read request
  input wire i_pending_set, // other logic marks 78h pending
  output reg o_status_output_flag, // reads return status
  output reg o_status_enhanced_pending_flag, // 78h pending
  output reg [7:0] o_selected_lun, // selected lun
  output reg [23:0] o_row_addr, // received row address
  output reg o_lun_notify, // one cycle 78h notice to all luns
  output reg o_status_rd, // one cycle select lun status onto bus
  output reg o_status_70h_ack, // one cycle honoured 70h
  output reg [2:0] o_state // current state
);
  // state codes, binary so the status register shows them directly
  localparam [2:0] ST_IDLE = `SEF_ST_IDLE;
  localparam [2:0] ST_WAIT = `SEF_ST_WAIT;
  localparam [2:0] ST_STORE = `SEF_ST_STORE;
  localparam [2:0] ST_SELECT = `SEF_ST_SELECT;
  localparam [2:0] ST_IDLE_RD = `SEF_ST_IDLE_RD;
  localparam [2:0] ST_IDLE_RD_STATUS = `SEF_ST_IDLE_RD_STATUS;

  // registers and their next values
  reg [2:0] saved_return_state_r;
  reg [2:0] saved_return_state_nxt;
  reg [1:0] cyc_cnt_r;
  reg [1:0] cyc_cnt_nxt;
  reg [2:0] state_nxt;
  reg status_output_nxt;
  reg pending_nxt;
  reg [7:0] selected_lun_nxt;
  reg [23:0] row_addr_nxt;
  reg lun_notify_nxt;
  reg status_rd_nxt;
  reg status_70h_ack_nxt;

  // configuration from the register block
  wire [1:0] row_cycles;
  wire [4:0] lun_shift;
  wire [2:0] ret_preset;
  wire [1:0] last_cyc;
  wire cmd_enh;
  wire cmd_plain;

  // lun index from row address, shift is configured
  function [7:0] lun_of;
    input [23:0] row;
    input [4:0] sh;
    reg [23:0] tmp;
    begin
      tmp = row >> sh;
      lun_of = tmp[7:0];
    end
  endfunction

  // three bytes of holding register, so a larger count is capped at three cycles
  assign last_cyc = (row_cycles > `SEF_ROWCYC_MAX) ? `SEF_ROWCYC_MAX : row_cycles;
  assign cmd_enh = i_cmd_valid && (i_cmd == `SEF_CMD_STATUS_ENH);
  assign cmd_plain = i_cmd_valid && (i_cmd == `SEF_CMD_STATUS);

  // next values; defaults first so no latch is inferred
  always @* begin
    state_nxt = o_state;
    status_output_nxt = o_status_output_flag;
    pending_nxt = o_status_enhanced_pending_flag;
    selected_lun_nxt = o_selected_lun;
    row_addr_nxt = o_row_addr;
    lun_notify_nxt = 1'b0;
    status_rd_nxt = 1'b0;
    status_70h_ack_nxt = 1'b0;
    saved_return_state_nxt = saved_return_state_r;
    cyc_cnt_nxt = cyc_cnt_r;
    // a set arriving outside the wait state is kept
    if (i_pending_set) begin
      pending_nxt = 1'b1;
    end
    case (o_state)
      ST_WAIT: begin
        // set wins over the clear so a fresh request is not lost
        pending_nxt = i_pending_set;
        status_output_nxt = 1'b1;
        if (i_addr_valid) begin
          state_nxt = ST_STORE;
          case (cyc_cnt_r)
            2'h0: row_addr_nxt[7:0] = i_addr;
            2'h1: row_addr_nxt[15:8] = i_addr;
            default: row_addr_nxt[23:16] = i_addr;
          endcase
        end
      end
      ST_STORE: begin
        if (cyc_cnt_r >= last_cyc) begin
          state_nxt = ST_SELECT;
        end else begin
          cyc_cnt_nxt = cyc_cnt_r + 2'h1;
          state_nxt = ST_WAIT;
        end
      end
      ST_SELECT: begin
        selected_lun_nxt = lun_of(o_row_addr, lun_shift);
        lun_notify_nxt = 1'b1;
        if (saved_return_state_r == ST_IDLE) begin
          state_nxt = ST_IDLE_RD;
        end else begin
          state_nxt = saved_return_state_r;
        end
      end
      default: begin
        // idle and other states accept new commands
        if (cmd_enh) begin
          cyc_cnt_nxt = 2'h0;
          saved_return_state_nxt = ret_preset;
          state_nxt = ST_WAIT;
        end else if (cmd_plain) begin
          // illegal while pending, so ignored then
          if (!o_status_enhanced_pending_flag) begin
            status_output_nxt = 1'b1;
            status_70h_ack_nxt = 1'b1;
            state_nxt = ST_IDLE_RD;
          end
        end else if (i_read_req && o_status_output_flag) begin
          status_rd_nxt = 1'b1;
          state_nxt = ST_IDLE_RD_STATUS;
        end
      end
    endcase
  end

  // sequencer state, cycle count and return state
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_state <= ST_IDLE;
      cyc_cnt_r <= 2'h0;
      saved_return_state_r <= `SEF_RET_RST;
    end else begin
      o_state <= state_nxt;
      cyc_cnt_r <= cyc_cnt_nxt;
      saved_return_state_r <= saved_return_state_nxt;
    end
  end

  // level flags seen by the host and the read path
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_status_output_flag <= 1'b0;
      o_status_enhanced_pending_flag <= 1'b0;
    end else begin
      o_status_output_flag <= status_output_nxt;
      o_status_enhanced_pending_flag <= pending_nxt;
    end
  end

  // row address and selected lun, kept until the next 78h overwrites them
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_selected_lun <= 8'h00;
      o_row_addr <= 24'h000000;
    end else begin
      o_selected_lun <= selected_lun_nxt;
      o_row_addr <= row_addr_nxt;
    end
  end

  // one cycle notices, registered so luns see clean pulses
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_lun_notify <= 1'b0;
      o_status_rd <= 1'b0;
      o_status_70h_ack <= 1'b0;
    end else begin
      o_lun_notify <= lun_notify_nxt;
      o_status_rd <= status_rd_nxt;
      o_status_70h_ack <= status_70h_ack_nxt;
    end
  end

  // configuration and visibility over apb
  sef_apb_regs u_regs (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_row_cycles(row_cycles),
    .o_lun_shift(lun_shift),
    .o_ret_state(ret_preset),
    .i_state(o_state),
    .i_pending(o_status_enhanced_pending_flag),
    .i_stat_out(o_status_output_flag),
    .i_row_addr({8'h00, o_row_addr}),
    .i_lun(o_selected_lun)
  );
endmodule
`default_nettype wire

// file: hdl/sef_defs.vh
// constants for the status enhanced command fragment
`ifndef SEF_DEFS_VH
`define SEF_DEFS_VH

// apb register byte offsets
`define SEF_REG_CTRL 8'h00
`define SEF_REG_STATUS 8'h04
`define SEF_REG_ROWADDR 8'h08
`define SEF_REG_LUN 8'h0C

// control register fields
`define SEF_CTRL_ROWCYC_LSB 0
`define SEF_CTRL_ROWCYC_MSB 1
`define SEF_CTRL_LUNSHIFT_LSB 8
`define SEF_CTRL_LUNSHIFT_MSB 12
`define SEF_CTRL_RET_LSB 16
`define SEF_CTRL_RET_MSB 18

// reset values
`define SEF_ROWCYC_RST 2'h3
`define SEF_LUNSHIFT_RST 5'h10
`define SEF_RET_RST 3'h0

// largest row cycle index, the holding register has three bytes
`define SEF_ROWCYC_MAX 2'h2

// state codes
`define SEF_ST_IDLE 3'h0
`define SEF_ST_WAIT 3'h1
`define SEF_ST_STORE 3'h2
`define SEF_ST_SELECT 3'h3
`define SEF_ST_IDLE_RD 3'h4
`define SEF_ST_IDLE_RD_STATUS 3'h5
`define SEF_ST_OTHER 3'h6

// command codes
`define SEF_CMD_STATUS 8'h70
`define SEF_CMD_STATUS_ENH 8'h78

`endif

// file: hdl/sef_apb_regs.v
// apb slave holding configuration and showing fragment state
`timescale 1ns/100ps
`default_nettype none
`include "sef_defs.vh"
module sef_apb_regs (
  input wire i_ref_clk, // 20 mhz clock
  input wire i_sys_rst, // sync reset, high
  input wire i_psel, // apb select
  input wire i_penable, // apb enable
  input wire i_pwrite, // apb direction
  input wire [7:0] i_paddr, // apb byte address
  input wire [31:0] i_pwdata, // apb write data
  output wire [31:0] o_prdata, // apb read data
  output wire o_pready, // apb ready
  output wire o_pslverr, // apb error
  output wire [1:0] o_row_cycles, // row address cycles minus one
  output wire [4:0] o_lun_shift, // row bit holding lun
  output wire [2:0] o_ret_state, // return state preset
  input wire [2:0] i_state, // fragment state
  input wire i_pending, // pending flag
  input wire i_stat_out, // status output flag
  input wire [31:0] i_row_addr, // row address register
  input wire [7:0] i_lun // selected lun
);
  reg [31:0] ctrl_r;
  reg [31:0] rdata_r;
  wire acc = i_psel & i_penable;
  wire hit = (i_paddr == `SEF_REG_CTRL) || (i_paddr == `SEF_REG_STATUS) ||
             (i_paddr == `SEF_REG_ROWADDR) || (i_paddr == `SEF_REG_LUN);

  // zero wait state: answer in the first access cycle
  assign o_pready = 1'b1;
  assign o_pslverr = acc & ~hit;
  assign o_prdata = rdata_r;
  assign o_row_cycles = ctrl_r[`SEF_CTRL_ROWCYC_MSB:`SEF_CTRL_ROWCYC_LSB];
  assign o_lun_shift = ctrl_r[`SEF_CTRL_LUNSHIFT_MSB:`SEF_CTRL_LUNSHIFT_LSB];
  assign o_ret_state = ctrl_r[`SEF_CTRL_RET_MSB:`SEF_CTRL_RET_LSB];

  // control write, only the defined fields are kept
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctrl_r <= {13'h0000, `SEF_RET_RST, 3'h0, `SEF_LUNSHIFT_RST, 6'h00, `SEF_ROWCYC_RST};
    end else if (acc && i_pwrite && i_paddr == `SEF_REG_CTRL) begin
      ctrl_r <= {13'h0000, i_pwdata[18:16], 3'h0, i_pwdata[12:8], 6'h00, i_pwdata[1:0]};
    end
  end

  // read data registered in setup so it is valid in the access cycle
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rdata_r <= 32'h00000000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      if (i_paddr == `SEF_REG_CTRL) begin
        rdata_r <= ctrl_r;
      end else if (i_paddr == `SEF_REG_STATUS) begin
        rdata_r <= {27'h0000000, i_stat_out, i_pending, i_state};
      end else if (i_paddr == `SEF_REG_ROWADDR) begin
        rdata_r <= i_row_addr;
      end else if (i_paddr == `SEF_REG_LUN) begin
        rdata_r <= {24'h000000, i_lun};
      end else begin
        rdata_r <= 32'h00000000;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/sef_status_enh_monitor.sv
// checker for the status enhanced command fragment
`timescale 1ns/100ps
`default_nettype none
module sef_status_enh_monitor (
  input wire logic i_ref_clk, // clock
  input wire logic i_sys_rst, // sync reset
  input wire logic i_cmd_valid, // command strobe
  input wire logic [7:0] i_cmd, // command code
  input wire logic i_addr_valid, // address strobe
  input wire logic i_read_req, // read request
  input wire logic i_pending_set, // pending set
  input wire logic o_status_output_flag, // status out
  input wire logic o_status_enhanced_pending_flag, // pending
  input wire logic o_lun_notify, // lun notice
  input wire logic o_status_rd, // status read
  input wire logic o_status_70h_ack, // 70h ack
  input wire logic [2:0] o_state // state
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  a_wait_hold: assert property (o_state == 3'h1 && !i_addr_valid |=> o_state == 3'h1)
    else $error("wait left early");
  a_wait_store: assert property (o_state == 3'h1 && i_addr_valid |=> o_state == 3'h2)
    else $error("no store");
  a_pend_clear: assert property (o_state == 3'h1 && i_addr_valid && !i_pending_set
    |=> !o_status_enhanced_pending_flag) else $error("pending kept");
  a_statout_set: assert property (o_state == 3'h1 && i_addr_valid |=> o_status_output_flag)
    else $error("status out low");
  a_store_next: assert property (o_state == 3'h2 |=> o_state == 3'h1 || o_state == 3'h3)
    else $error("bad store exit");
  a_sel_notify: assert property (o_state == 3'h3 |=> o_lun_notify ##1 !o_lun_notify)
    else $error("no lun notice");
  a_sel_leave: assert property (o_state == 3'h3 |=> !(o_state inside {3'h1, 3'h2, 3'h3}))
    else $error("bad select exit");
  a_read_status: assert property (i_read_req && !i_cmd_valid && o_status_output_flag &&
    o_state inside {3'h0, 3'h4, 3'h5, 3'h6} |=> o_status_rd && o_state == 3'h5) else $error("no status read");
  a_plain_ign: assert property (i_cmd_valid && i_cmd == 8'h70 && o_status_enhanced_pending_flag
    |=> !o_status_70h_ack) else $error("70h honoured");
  cover property (o_lun_notify);
  cover property (o_status_rd);
  cover property (o_state == 3'h6);
endmodule
`default_nettype wire

// file: tb/sef_host_model.sv
// host flash controller issuing command and address cycles
`timescale 1ns/100ps
`default_nettype none
module sef_host_model (
  input wire logic i_ref_clk, // clock
  output logic o_cmd_valid = 1'b0, // command strobe
  output logic [7:0] o_cmd = 8'h00, // command code
  output logic o_addr_valid = 1'b0, // address strobe
  output logic [7:0] o_addr = 8'h00, // address value
  output logic o_read_req = 1'b0 // read request
);
  // one command cycle; no 78h after target level commands here
  task cmd(input logic [7:0] c);
    @(posedge i_ref_clk);
    o_cmd_valid <= 1'b1;
    o_cmd <= c;
    @(posedge i_ref_clk);
    o_cmd_valid <= 1'b0;
    o_cmd <= ~c; // released bus shows junk
  endtask
  // row cycles low byte first, gap adds idle cycles for a slow host
  task row(input logic [23:0] r, input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      o_addr_valid <= 1'b1;
      o_addr <= r[8*k+:8];
      @(posedge i_ref_clk);
      o_addr_valid <= 1'b0;
      o_addr <= ~r[8*k+:8];
      repeat (1 + gap) @(posedge i_ref_clk);
    end
  endtask
  task rd;
    @(posedge i_ref_clk);
    o_read_req <= 1'b1;
    @(posedge i_ref_clk);
    o_read_req <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/status_enhanced_cmd_fsm_test.sv
// self-checking bench for the status enhanced command fragment
`timescale 1ns/100ps
`default_nettype none
module status_enhanced_cmd_fsm_test;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pset = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, cv, av, rr, sout, pend, ntf, srd, ack;
  wire logic [7:0] cmd, adr, lun;
  wire logic [23:0] row;
  wire logic [2:0] st;
  int err_total = 0, cmp_count = 0, cyc = 0;
  always #25 clk = ~clk;
  sef_status_enh_fsm dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_cmd_valid(cv), .i_cmd(cmd), .i_addr_valid(av), .i_addr(adr), .i_read_req(rr), .i_pending_set(pset),
    .o_status_output_flag(sout), .o_status_enhanced_pending_flag(pend), .o_selected_lun(lun),
    .o_row_addr(row), .o_lun_notify(ntf), .o_status_rd(srd), .o_status_70h_ack(ack), .o_state(st));
  sef_host_model host (.i_ref_clk(clk), .o_cmd_valid(cv), .o_cmd(cmd), .o_addr_valid(av), .o_addr(adr),
    .o_read_req(rr));
  task chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // apb transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // defaults: three row cycles, lun in top byte, back to idle read
  task t_default;
    apb(1'b0, 8'h00, 32'h0); chk(q, 32'h0000_1003);
    apb(1'b0, 8'h10, 32'h0); chk({q[30:0], e}, 32'h1); // unmapped word
    host.cmd(8'h78); host.row(24'h0A5B3C, 3, 0);
    step(1); chk(st, 3'h4);
    chk(ntf, 1'b1);
    chk(row, 24'h0A5B3C);
    chk(lun, 8'h0A);
    apb(1'b0, 8'h08, 32'h0); chk(q, 32'h000A_5B3C);
    apb(1'b0, 8'h0C, 32'h0); chk(q, 32'h0000_000A);
    host.rd; #1; chk({srd, st}, 4'hD);
  endtask
  // two slow row cycles, lun in middle byte, saved state six
  task t_short;
    apb(1'b1, 8'h00, 32'h0006_0801);
    host.cmd(8'h78); host.row(24'h337712, 2, 3);
    step(1); chk(st, 3'h6);
    chk(row[15:0], 16'h7712);
    chk(lun, 8'h77);
    apb(1'b0, 8'h04, 32'h0); chk(q, 32'h16);
  endtask
  // plain status refused while pending, honoured after it clears
  task t_pend;
    @(posedge clk) pset <= 1'b1;
    @(posedge clk) pset <= 1'b0;
    host.cmd(8'h70); #1; chk({pend, ack}, 2'h2);
    apb(1'b1, 8'h00, 32'h0000_1003);
    host.cmd(8'h78); host.row(24'h010203, 3, 0);
    step(1); chk({pend, st}, 4'h4);
    host.cmd(8'h70); #1; chk(ack, 1'b1);
  endtask
  task print_verdict;
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // cycle ceiling well above the fewer than a hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_default;
    t_short;
    t_pend;
    print_verdict;
  end
endmodule
bind sef_status_enh_fsm sef_status_enh_monitor mon (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_addr_valid(i_addr_valid), .i_read_req(i_read_req),
  .i_pending_set(i_pending_set), .o_status_output_flag(o_status_output_flag),
  .o_status_enhanced_pending_flag(o_status_enhanced_pending_flag), .o_lun_notify(o_lun_notify),
  .o_status_rd(o_status_rd), .o_status_70h_ack(o_status_70h_ack), .o_state(o_state));
`default_nettype wire
